/* pkg/debug_pkg.sv */
package debug_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_TRACE_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESET_REASON = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_PIN_DRIVE = 8'h14;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h18;

  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SPEED_LSB = 2;
  localparam logic [5:0] TRACE_CONFIG_RESET = 6'h00;
  localparam logic [1:0] TRACE_OFF = 2'h0;
  localparam logic [1:0] TRACE_PARALLEL = 2'h1;
  localparam logic [1:0] TRACE_SERIAL = 2'h2;

  localparam int STATUS_DEBUG_MODE = 0;
  localparam int STATUS_SYSTEM_OFF = 1;
  localparam int STATUS_HALTED = 2;
  localparam int STATUS_PROTECT = 3;
  localparam int STATUS_TRACE_ACTIVE = 4;

  localparam int IRQ_DEBUG_ENTER = 0;
  localparam int IRQ_DEBUG_LEAVE = 1;
  localparam int IRQ_DEBUG_WAKE = 2;
  localparam int IRQ_WIDTH = 3;

  localparam int POWER_OFF_BIT = 0;
  localparam int PIN_COUNT = 5;
  localparam int TRACE_CLOCK_PIN = 4;
  localparam logic [4:0] PIN_DRIVE_RESET = 5'h00;

  // ----------------------------------------
  // Trace timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRACE_PERIOD0_NS = 80;
  localparam int TRACE_PERIOD1_NS = 160;
  localparam int TRACE_PERIOD2_NS = 320;
  localparam int TRACE_PERIOD3_NS = 500;
  localparam logic [7:0] TRACE_HALF0 = 8'(TRACE_PERIOD0_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] TRACE_HALF1 = 8'(TRACE_PERIOD1_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] TRACE_HALF2 = 8'(TRACE_PERIOD2_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] TRACE_HALF3 = 8'(TRACE_PERIOD3_NS / (2 * CLK_PERIOD_NS));
  localparam logic [3:0] PARALLEL_UNITS = 4'h2;
  localparam logic [3:0] SERIAL_UNITS = 4'ha;

endpackage

/* hdl/level_sync.sv */
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= '0;
      sync_out <= '0;
    end else begin
      stage <= async_in;
      sync_out <= stage;
    end
  end

endmodule

/* hdl/trace_port_unit.sv */
module trace_port_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [7:0] half_count,
  input wire logic instr_valid,
  input wire logic [7:0] instr_data,
  output logic instr_ready,
  input wire logic soft_valid,
  input wire logic [7:0] soft_data,
  output logic soft_ready,
  output logic [3:0] trace_data_bus,
  output logic trace_clock_out,
  output logic serial_trace_output,
  output logic active
);

  logic [1:0] mode_q;
  logic [7:0] count;
  logic phase;
  logic [9:0] shreg;
  logic [3:0] units_left;
  logic parallel;
  logic serial;
  logic step;
  logic free_slot;
  logic take_soft;
  logic take_instr;
  logic mode_change;

  assign parallel = (mode == debug_pkg::TRACE_PARALLEL);
  assign serial = (mode == debug_pkg::TRACE_SERIAL);
  assign mode_change = (mode != mode_q);
  // One unit per full trace clock period, advanced just before its falling edge
  assign step = (count == 8'h00) && phase && !mode_change;
  assign free_slot = step && (units_left <= 4'h1);
  // Software trace first; instruction trace never on the serial pin
  assign take_soft = free_slot && soft_valid && (parallel || serial);
  assign take_instr = free_slot && !take_soft && instr_valid && parallel;
  // Sources outside their mode are drained, not stalled
  assign soft_ready = take_soft || !(parallel || serial);
  assign instr_ready = take_instr || !parallel;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= debug_pkg::TRACE_OFF;
      count <= 8'h00;
      phase <= 1'b0;
    end else begin
      mode_q <= mode;
      if (mode_change || count == 8'h00) begin
        count <= half_count - 8'h01;
        phase <= mode_change ? 1'b0 : !phase;
      end else begin
        count <= count - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg <= 10'h3ff;
      units_left <= 4'h0;
    end else if (mode_change) begin
      shreg <= 10'h3ff;
      units_left <= 4'h0;
    end else if (step) begin
      if (units_left > 4'h1) begin
        shreg <= parallel ? {4'hf, shreg[9:4]} : {1'b1, shreg[9:1]};
        units_left <= units_left - 4'h1;
      end else if (take_soft || take_instr) begin
        if (parallel) begin
          shreg <= {2'h3, take_soft ? soft_data : instr_data};
          units_left <= debug_pkg::PARALLEL_UNITS;
        end else begin
          // Stop bit, data LSB first, start bit
          shreg <= {1'b1, soft_data, 1'b0};
          units_left <= debug_pkg::SERIAL_UNITS;
        end
      end else begin
        shreg <= 10'h3ff;
        units_left <= 4'h0;
      end
    end
  end

  // Idle parallel bus shows zero, idle serial line stays high
  assign trace_data_bus = (units_left != 4'h0) ? shreg[3:0] : 4'h0;
  assign trace_clock_out = phase && parallel;
  assign serial_trace_output = (units_left != 4'h0) ? shreg[0] : 1'b1;
  assign active = (units_left != 4'h0);

endmodule

/* hdl/debug_power_trace.sv */
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
module debug_power_trace (
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  // Debugger power request, from the debug link domain
  input wire logic debug_power_request,
  output logic debug_mode,
  output logic system_off,
  // Power manager
  input wire logic cpu_active,
  output logic regulator_enable,
  output logic regulator_high_power,
  output logic hf_clock_enable,
  // Halt and interrupt priority, lower value is more urgent
  input wire logic breakpoint_hit,
  input wire logic [2:0] breakpoint_priority,
  input wire logic resume,
  input wire logic irq_pending,
  input wire logic [2:0] irq_priority,
  output logic core_halted,
  output logic irq_service,
  // Access port protection
  input wire logic watchdog_reset,
  input wire logic protect_disable,
  output logic access_protect,
  // Trace sources
  input wire logic instr_valid,
  input wire logic [7:0] instr_data,
  output logic instr_ready,
  input wire logic soft_valid,
  input wire logic [7:0] soft_data,
  output logic soft_ready,
  // Shared pins
  input wire logic [4:0] gpio_user_out,
  input wire logic [4:0] gpio_user_oe,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [4:0] pin_drive_high
);

  // ----------------------------------------
  // Debug power request
  // ----------------------------------------
  logic request_sync;
  logic request_q;
  logic debug_enter;
  logic debug_leave;
  logic wake_event;

  level_sync #(.WIDTH(1)) request_sync_inst (
    .clk(clk),
    .rst(rst),
    .async_in(debug_power_request),
    .sync_out(request_sync)
  );

  assign debug_enter = request_sync && !request_q;
  assign debug_leave = !request_sync && request_q;
  assign wake_event = system_off && request_sync;
  // Mode follows the synchronised request and nothing else
  assign debug_mode = request_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_q <= 1'b0;
    end else begin
      request_q <= request_sync;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic [7:0] wr_addr;
  logic wr_pending;
  logic addr_phase;
  logic wr_cycle;
  logic [31:0] read_value;
  logic [5:0] trace_config;
  logic [4:0] pin_drive;
  logic [2:0] reset_reason;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;
  logic [4:0] status_word;
  logic wr_config;
  logic wr_reason;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_drive;
  logic wr_power;
  logic trace_active;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_cycle = wr_pending;
  assign wr_config = wr_cycle && (wr_addr == debug_pkg::ADDR_TRACE_CONFIG);
  assign wr_reason = wr_cycle && (wr_addr == debug_pkg::ADDR_RESET_REASON);
  assign wr_irq_status = wr_cycle && (wr_addr == debug_pkg::ADDR_IRQ_STATUS);
  assign wr_irq_mask = wr_cycle && (wr_addr == debug_pkg::ADDR_IRQ_MASK);
  assign wr_drive = wr_cycle && (wr_addr == debug_pkg::ADDR_PIN_DRIVE);
  assign wr_power = wr_cycle && (wr_addr == debug_pkg::ADDR_POWER_CONTROL);
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    status_word = 5'h00;
    status_word[debug_pkg::STATUS_DEBUG_MODE] = debug_mode;
    status_word[debug_pkg::STATUS_SYSTEM_OFF] = system_off;
    status_word[debug_pkg::STATUS_HALTED] = core_halted;
    status_word[debug_pkg::STATUS_PROTECT] = access_protect;
    status_word[debug_pkg::STATUS_TRACE_ACTIVE] = trace_active;
  end

  // Unmapped offsets read zero and ignore writes
  always_comb begin
    unique case (haddr[7:0])
      debug_pkg::ADDR_TRACE_CONFIG: read_value = {26'h0, trace_config};
      debug_pkg::ADDR_STATUS: read_value = {27'h0, status_word};
      debug_pkg::ADDR_RESET_REASON: read_value = {29'h0, reset_reason};
      debug_pkg::ADDR_IRQ_STATUS: read_value = {29'h0, irq_status};
      debug_pkg::ADDR_IRQ_MASK: read_value = {29'h0, irq_mask};
      debug_pkg::ADDR_PIN_DRIVE: read_value = {27'h0, pin_drive};
      default: read_value = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pending <= addr_phase && hwrite && (haddr[31:8] == 24'h0);
      if (addr_phase) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        hrdata <= (haddr[31:8] == 24'h0) ? read_value : 32'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trace_config <= debug_pkg::TRACE_CONFIG_RESET;
      pin_drive <= debug_pkg::PIN_DRIVE_RESET;
      irq_mask <= 3'h0;
    end else begin
      if (wr_config) begin
        trace_config <= hwdata[5:0];
      end
      if (wr_drive) begin
        pin_drive <= hwdata[4:0];
      end
      if (wr_irq_mask) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Sticky flags, a new event beats the clear
  // ----------------------------------------
  assign irq_events = {wake_event, debug_leave, debug_enter};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_reason <= 3'h0;
      irq_status <= 3'h0;
    end else begin
      reset_reason[0] <= wake_event ||
                         (reset_reason[0] && !(wr_reason && hwdata[0]));
      reset_reason[2:1] <= 2'h0;
      irq_status <= irq_events | (irq_status & ~(wr_irq_status ? hwdata[2:0] : 3'h0));
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // System off and power manager
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_off <= 1'b0;
    end else if (wake_event) begin
      system_off <= 1'b0;
    end else if (wr_power && hwdata[debug_pkg::POWER_OFF_BIT] &&
                 !request_sync && !request_q) begin
      system_off <= 1'b1;
    end
  end

  // Debug mode keeps everything up, costing power until released
  assign regulator_enable = !system_off || debug_mode;
  assign regulator_high_power = debug_mode || trace_active || cpu_active;
  assign hf_clock_enable = (!system_off && (cpu_active || trace_active)) ||
                           debug_mode;

  // ----------------------------------------
  // Halting with real-time interrupts
  // ----------------------------------------
  logic [2:0] halt_level;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_halted <= 1'b0;
      halt_level <= 3'h0;
    end else if (!debug_mode || resume) begin
      core_halted <= 1'b0;
    end else if (breakpoint_hit && !core_halted) begin
      core_halted <= 1'b1;
      halt_level <= breakpoint_priority;
    end
  end

  // More urgent handlers keep running while lower code is halted
  assign irq_service = irq_pending && (!core_halted || irq_priority < halt_level);

  // ----------------------------------------
  // Access port protection
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      access_protect <= 1'b1;
    end else if (watchdog_reset && !debug_mode) begin
      access_protect <= 1'b1;
    end else if (protect_disable) begin
      access_protect <= 1'b0;
    end
  end

  // ----------------------------------------
  // Trace and pin sharing
  // ----------------------------------------
  logic [1:0] trace_mode;
  logic [7:0] half_count;
  logic [3:0] trace_data_bus;
  logic trace_clock_out;
  logic serial_trace_output;
  logic [4:0] next_pin_out;
  logic [4:0] next_pin_oe;

  // Code 3 is treated as off so both modes are never on together
  assign trace_mode = trace_config[debug_pkg::CFG_MODE_LSB +: 2];
  assign half_count =
    (trace_config[debug_pkg::CFG_SPEED_LSB +: 2] == 2'h0) ? debug_pkg::TRACE_HALF0 :
    (trace_config[debug_pkg::CFG_SPEED_LSB +: 2] == 2'h1) ? debug_pkg::TRACE_HALF1 :
    (trace_config[debug_pkg::CFG_SPEED_LSB +: 2] == 2'h2) ? debug_pkg::TRACE_HALF2 :
    debug_pkg::TRACE_HALF3;

  trace_port_unit trace_port_unit_inst (
    .clk(clk),
    .rst(rst),
    .mode(trace_mode),
    .half_count(half_count),
    .instr_valid(instr_valid),
    .instr_data(instr_data),
    .instr_ready(instr_ready),
    .soft_valid(soft_valid),
    .soft_data(soft_data),
    .soft_ready(soft_ready),
    .trace_data_bus(trace_data_bus),
    .trace_clock_out(trace_clock_out),
    .serial_trace_output(serial_trace_output),
    .active(trace_active)
  );

  always_comb begin
    next_pin_out = gpio_user_out;
    next_pin_oe = gpio_user_oe;
    if (trace_mode == debug_pkg::TRACE_PARALLEL) begin
      next_pin_out = {trace_clock_out, trace_data_bus};
      next_pin_oe = 5'h1f;
    end else if (trace_mode == debug_pkg::TRACE_SERIAL) begin
      // Serial output borrows data bit zero's pin only
      next_pin_out[0] = serial_trace_output;
      next_pin_oe[0] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= 5'h00;
      pin_oe <= 5'h00;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  assign pin_drive_high = pin_drive;

endmodule

/* dv/debug_power_trace_checker.sv */
module debug_power_trace_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic debug_power_request,
  input wire logic debug_mode,
  input wire logic system_off,
  input wire logic cpu_active,
  input wire logic regulator_enable,
  input wire logic hf_clock_enable,
  input wire logic [2:0] breakpoint_priority,
  input wire logic irq_pending,
  input wire logic [2:0] irq_priority,
  input wire logic core_halted,
  input wire logic irq_service,
  input wire logic watchdog_reset,
  input wire logic protect_disable,
  input wire logic access_protect
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_mode_enter: assert property (debug_power_request [*4] |-> debug_mode)
    else $error("debug mode missing while requested");
  a_mode_leave: assert property (!debug_power_request [*4] |-> !debug_mode)
    else $error("debug mode kept after release");
  a_mode_sync: assert property ($rose(debug_power_request) |=> !debug_mode)
    else $error("request used before synchronising");
  a_wake_on: assert property (debug_mode |-> !system_off)
    else $error("system off during debug mode");
  a_halt_drop: assert property ($fell(debug_mode) |-> ##[0:1] !core_halted)
    else $error("halt kept after debug mode ended");
  a_irq_preempt: assert property (core_halted && irq_pending &&
    irq_priority < breakpoint_priority |-> irq_service)
    else $error("urgent interrupt blocked by halt");
  a_wdog_protect: assert property (watchdog_reset && !debug_mode |=> access_protect)
    else $error("watchdog left port unprotected");
  a_wdog_debug: assert property (watchdog_reset && debug_mode &&
    !access_protect && !protect_disable |=> !access_protect)
    else $error("watchdog protected port in debug mode");
  a_power_on: assert property (cpu_active |-> hf_clock_enable && regulator_enable)
    else $error("resources off while cpu active");
endmodule

bind debug_power_trace debug_power_trace_checker checker_inst (.clk, .rst, .hreadyout,
  .hresp, .debug_power_request, .debug_mode, .system_off, .cpu_active,
  .regulator_enable, .hf_clock_enable, .breakpoint_priority, .irq_pending,
  .irq_priority, .core_halted, .irq_service, .watchdog_reset, .protect_disable,
  .access_protect);

/* dv/debug_probe_model.sv */
module debug_probe_model (
  input wire logic clk,
  output logic debug_power_request,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic link_clk = 1'b0;
  logic link_on = 1'b0;
  logic [3:0] nib_q[$];
  logic [7:0] ser_q[$];
  int bit_cycles = 0;

  initial debug_power_request = 1'b0;

  // Link clock stands still between sessions
  always begin
    #80;
    if (link_on) link_clk = ~link_clk;
  end

  // Request raised before any port access, dropped when done
  task session(input logic on);
    link_on = 1'b1;
    @(posedge link_clk);
    debug_power_request <= on;
    @(negedge link_clk);
    link_on = 1'b0;
  endtask

  // Data changes as the trace clock falls, so its rise is safe
  always @(posedge pin_out[4]) begin
    if (pin_oe[4] && bit_cycles == 0) nib_q.push_back(pin_out[3:0]);
  end

  always @(negedge pin_out[0]) begin
    logic [7:0] d;
    if (bit_cycles > 0 && pin_oe[0]) begin
      repeat (bit_cycles / 2) @(negedge clk);
      if (pin_out[0] === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (bit_cycles) @(negedge clk);
          d[i] = pin_out[0];
        end
        repeat (bit_cycles) @(negedge clk);
        if (pin_out[0] === 1'b1) ser_q.push_back(d);
      end
    end
  end
endmodule

/* dv/debug_power_trace_test.sv */
module debug_power_trace_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, breakpoint_priority = 0, irq_priority = 0;
  logic debug_power_request, debug_mode, system_off, cpu_active = 0;
  logic regulator_enable, regulator_high_power, hf_clock_enable;
  logic breakpoint_hit = 0, resume = 0, irq_pending = 0, core_halted, irq_service;
  logic watchdog_reset = 0, protect_disable = 0, access_protect;
  logic instr_valid = 0, soft_valid = 0, instr_ready, soft_ready;
  logic [7:0] instr_data = 0, soft_data = 0;
  logic [4:0] gpio_user_out = 0, gpio_user_oe = 0, pin_out, pin_oe, pin_drive_high;
  int n_errors = 0, total_checks = 0, cycles = 0;
  int per[4] = '{debug_pkg::TRACE_PERIOD0_NS, debug_pkg::TRACE_PERIOD1_NS,
    debug_pkg::TRACE_PERIOD2_NS, debug_pkg::TRACE_PERIOD3_NS};
  logic [7:0] exp_q[$];

  assign hready = hreadyout;
  always #5 clk = ~clk;

  debug_power_trace debug_power_trace_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .debug_power_request,
    .debug_mode, .system_off, .cpu_active, .regulator_enable, .regulator_high_power,
    .hf_clock_enable, .breakpoint_hit, .breakpoint_priority, .resume, .irq_pending,
    .irq_priority, .core_halted, .irq_service, .watchdog_reset, .protect_disable,
    .access_protect, .instr_valid, .instr_data, .instr_ready, .soft_valid, .soft_data,
    .soft_ready, .gpio_user_out, .gpio_user_oe, .pin_out, .pin_oe, .pin_drive_high);
  debug_probe_model debug_probe_model_inst (.clk, .debug_power_request, .pin_out, .pin_oe);

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task close_out;
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // A write needs a spare slot before its effect shows
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    if (wr) tick(2);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    check(rd, exp);
  endtask

  task pulse_in(input int which);
    if (which == 0) watchdog_reset <= 1;
    else if (which == 1) protect_disable <= 1;
    else if (which == 2) breakpoint_hit <= 1;
    else resume <= 1;
    tick(1);
    {watchdog_reset, protect_disable, breakpoint_hit, resume} <= 4'h0;
    tick(2);
  endtask

  task send(input logic sw, input logic [7:0] d);
    soft_valid <= sw;
    instr_valid <= !sw;
    soft_data <= d;
    instr_data <= d;
    do @(posedge clk); while ((sw ? soft_ready : instr_ready) !== 1'b1);
    soft_valid <= 0;
    instr_valid <= 0;
    // Let the drop be seen before the next raise
    tick(1);
  endtask

  initial begin
    logic [7:0] b;
    logic [3:0] nq[$];
    int p;
    void'($urandom(32'h2bfd0012));
    gpio_user_out <= 5'($urandom);
    gpio_user_oe <= 5'($urandom);
    cpu_active <= 1'($urandom);
    tick(20);
    rst <= 0;
    tick(3);
    check(pin_drive_high, 0);
    check(pin_out, gpio_user_out);
    check(pin_oe, gpio_user_oe);
    rdchk(debug_pkg::ADDR_PIN_DRIVE, 0);
    rdchk(debug_pkg::ADDR_STATUS, 32'h8);
    rdchk(8'h1c, 0);
    cpu_active <= 0;
    bus(1, debug_pkg::ADDR_POWER_CONTROL, 1);
    check(system_off, 1);
    check(regulator_enable, 0);
    check(hf_clock_enable, 0);
    debug_probe_model_inst.session(1);
    tick(6);
    check(debug_mode, 1);
    check(regulator_high_power, 1);
    check(hf_clock_enable, 1);
    check(system_off, 0);
    rdchk(debug_pkg::ADDR_RESET_REASON, 1);
    rdchk(debug_pkg::ADDR_IRQ_STATUS, 5);
    check(irq, 0);
    bus(1, debug_pkg::ADDR_IRQ_MASK, 4);
    check(irq, 1);
    bus(1, debug_pkg::ADDR_POWER_CONTROL, 1);
    check(system_off, 0);
    bus(1, debug_pkg::ADDR_IRQ_STATUS, 7);
    bus(1, debug_pkg::ADDR_RESET_REASON, 1);
    check(irq, 0);
    rdchk(debug_pkg::ADDR_RESET_REASON, 0);
    pulse_in(1);
    check(access_protect, 0);
    pulse_in(0);
    check(access_protect, 0);
    breakpoint_priority <= 3'h4;
    pulse_in(2);
    check(core_halted, 1);
    for (int i = 0; i < 8; i++) begin
      irq_priority <= 3'(i);
      irq_pending <= 1;
      tick(1);
      check(irq_service, 32'(i < 4));
    end
    irq_pending <= 0;
    pulse_in(3);
    check(core_halted, 0);
    pulse_in(2);
    debug_probe_model_inst.session(0);
    tick(6);
    check(debug_mode, 0);
    check(regulator_high_power, 32'(cpu_active));
    check(core_halted, 0);
    rdchk(debug_pkg::ADDR_IRQ_STATUS, 2);
    pulse_in(0);
    check(access_protect, 1);
    cpu_active <= 1'($urandom);
    bus(1, debug_pkg::ADDR_PIN_DRIVE, 32'h1f);
    check(pin_drive_high, 5'h1f);
    bus(1, debug_pkg::ADDR_TRACE_CONFIG, 1);
    rdchk(debug_pkg::ADDR_TRACE_CONFIG, 1);
    check(pin_oe, 5'h1f);
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom) | 8'h11;
      send(i[0], b);
      exp_q.push_back(b);
    end
    tick(40);
    nq = debug_probe_model_inst.nib_q;
    p = 0;
    foreach (exp_q[k]) begin
      while (p + 1 < nq.size() && !(nq[p] == exp_q[k][3:0] && nq[p+1] == exp_q[k][7:4])) p++;
      check(32'(p + 1 < nq.size()), 1);
      p += 2;
    end
    for (int s = 0; s < 4; s++) begin
      bus(1, debug_pkg::ADDR_TRACE_CONFIG, 32'(s * 4 + 2));
      debug_probe_model_inst.bit_cycles = per[s] / debug_pkg::CLK_PERIOD_NS;
      check(pin_oe[4], gpio_user_oe[4]);
      send(0, 8'h5a);
      b = 8'($urandom);
      send(1, b);
      tick(13 * debug_probe_model_inst.bit_cycles);
      check(debug_probe_model_inst.ser_q.size(), 1);
      if (debug_probe_model_inst.ser_q.size() > 0) begin
        check(debug_probe_model_inst.ser_q.pop_front(), b);
      end
      debug_probe_model_inst.ser_q.delete();
    end
    bus(1, debug_pkg::ADDR_TRACE_CONFIG, 3);
    check(pin_oe, gpio_user_oe);
    check(pin_out, gpio_user_out);
    close_out();
  end
endmodule
